//--- rtl/eeprom_byte_access_control.sv
// Purpose: Software access to single bytes of the data EEPROM over AXI4-Lite.
// Assumes: rc_tick and flash_self_program_active are synchronous to aclk; the array
//          returns nv_rdata one cycle after nv_rd_en.
// Notes: CPU stalls hold the write response, so the next write waits for them; the read channel does not.
//
// Local design decisions: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module eeprom_byte_access_control
#(
    parameter logic [14:0] TICKS_ATOMIC = eeprom_access_pkg::ATOMIC_TICKS,
    parameter logic [14:0] TICKS_SPLIT = eeprom_access_pkg::SPLIT_TICKS
)
(
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write channels.
    input wire logic [4:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read channels.
    input wire logic [4:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Timing and interlock inputs.
    input wire logic rc_tick,
    input wire logic flash_self_program_active,
    // EEPROM array side.
    output logic [11:0] nv_addr,
    output logic [7:0] nv_wdata,
    output logic [1:0] nv_op,
    output logic nv_write_start,
    output logic nv_rd_en,
    input wire logic [7:0] nv_rdata,
    // CPU side.
    output logic cpu_stall,
    output logic ready_irq,
    output logic irq
);

    eeprom_access_pkg::wr_state_t wr_state;
    logic aw_got;
    logic w_got;
    logic [4:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic [2:0] stall_count;
    logic master_write_arm;
    logic [2:0] arm_count;
    logic [1:0] program_op_select;
    logic ready_irq_enable;
    logic global_irq_enable;
    logic [11:0] nv_byte_pointer;
    logic [7:0] nv_byte_value;
    logic [eeprom_access_pkg::EV_COUNT-1:0] irq_status;
    logic [eeprom_access_pkg::EV_COUNT-1:0] irq_mask;
    logic [eeprom_access_pkg::EV_COUNT-1:0] events;
    logic rd_capture;
    logic program_strobe;
    logic write_done;
    logic [2:0] wr_sel;
    logic apply;
    logic ctl_wr;
    logic want_prog;
    logic want_read;
    logic [1:0] next_op;
    logic write_go;
    logic read_go;
    logic arm_load;
    logic [14:0] write_ticks;
    logic [31:0] next_rdata;

    // Decode of the write being applied; strobes written as zero do nothing.
    always_comb
    begin
        wr_sel = eeprom_access_pkg::reg_sel(wr_addr);
        apply = (wr_state == eeprom_access_pkg::WR_APPLY);
        ctl_wr = apply && (wr_sel == eeprom_access_pkg::SEL_CONTROL) && wr_strb[0];
        want_prog = ctl_wr && wr_data[eeprom_access_pkg::CTL_PROG];
        want_read = ctl_wr && wr_data[eeprom_access_pkg::CTL_READ];
        next_op = program_strobe ? program_op_select
            : wr_data[eeprom_access_pkg::CTL_OP_HI:eeprom_access_pkg::CTL_OP_LO];
        write_go = want_prog && master_write_arm && !program_strobe
            && !flash_self_program_active
            && (next_op != eeprom_access_pkg::OP_RESERVED);
        read_go = want_read && !program_strobe;
        arm_load = ctl_wr && wr_data[eeprom_access_pkg::CTL_ARM]
            && !wr_data[eeprom_access_pkg::CTL_PROG] && !master_write_arm;
        write_ticks = (next_op == eeprom_access_pkg::OP_ERASE_WRITE) ? TICKS_ATOMIC
            : TICKS_SPLIT;
    end

    // The write duration runs on oscillator ticks and survives a reset.
    nv_write_timer u_timer
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .start(write_go),
        .target(write_ticks),
        .rc_tick(rc_tick),
        .busy(program_strobe),
        .done(write_done)
    );

    // Write channel: takes address and data in either order, applies, stalls, answers.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wr_state <= eeprom_access_pkg::WR_IDLE;
            aw_got <= 1'b0;
            w_got <= 1'b0;
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= eeprom_access_pkg::RESP_OKAY;
            wr_addr <= 5'h00;
            wr_data <= 32'h0000_0000;
            wr_strb <= 4'h0;
            stall_count <= 3'h0;
            cpu_stall <= 1'b0;
        end
        else
        begin
            case (wr_state)
                eeprom_access_pkg::WR_IDLE:
                begin
                    if (awvalid && awready)
                    begin
                        aw_got <= 1'b1;
                        wr_addr <= awaddr;
                        awready <= 1'b0;
                    end
                    else if (!aw_got)
                    begin
                        awready <= 1'b1;
                    end
                    if (wvalid && wready)
                    begin
                        w_got <= 1'b1;
                        wr_data <= wdata;
                        wr_strb <= wstrb;
                        wready <= 1'b0;
                    end
                    else if (!w_got)
                    begin
                        wready <= 1'b1;
                    end
                    if ((aw_got || (awvalid && awready)) && (w_got || (wvalid && wready)))
                    begin
                        wr_state <= eeprom_access_pkg::WR_APPLY;
                    end
                end
                eeprom_access_pkg::WR_APPLY:
                begin
                    aw_got <= 1'b0;
                    w_got <= 1'b0;
                    bresp <= (wr_sel == eeprom_access_pkg::SEL_NONE)
                        ? eeprom_access_pkg::RESP_SLVERR : eeprom_access_pkg::RESP_OKAY;
                    if (write_go)
                    begin
                        stall_count <= eeprom_access_pkg::WRITE_STALL;
                        cpu_stall <= 1'b1;
                        wr_state <= eeprom_access_pkg::WR_STALL;
                    end
                    else if (read_go)
                    begin
                        stall_count <= eeprom_access_pkg::READ_STALL;
                        cpu_stall <= 1'b1;
                        wr_state <= eeprom_access_pkg::WR_STALL;
                    end
                    else
                    begin
                        bvalid <= 1'b1;
                        wr_state <= eeprom_access_pkg::WR_RESP;
                    end
                end
                eeprom_access_pkg::WR_STALL:
                begin
                    stall_count <= stall_count - 3'h1;
                    if (stall_count == 3'h1)
                    begin
                        cpu_stall <= 1'b0;
                        bvalid <= 1'b1;
                        wr_state <= eeprom_access_pkg::WR_RESP;
                    end
                end
                eeprom_access_pkg::WR_RESP:
                begin
                    if (bready)
                    begin
                        bvalid <= 1'b0;
                        wr_state <= eeprom_access_pkg::WR_IDLE;
                    end
                end
                default:
                begin
                    wr_state <= eeprom_access_pkg::WR_IDLE;
                end
            endcase
        end
    end

    // Arm window: loads only from idle so a re-arm cannot stretch it.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            master_write_arm <= 1'b0;
            arm_count <= 3'h0;
        end
        else if (arm_load)
        begin
            master_write_arm <= 1'b1;
            arm_count <= eeprom_access_pkg::ARM_WINDOW;
        end
        else if (master_write_arm)
        begin
            arm_count <= arm_count - 3'h1;
            if (arm_count == 3'h1)
            begin
                master_write_arm <= 1'b0;
            end
        end
    end

    // Control fields; the operation select keeps its value across a busy reset.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            if (!program_strobe)
            begin
                program_op_select <= eeprom_access_pkg::OP_RESET;
            end
            ready_irq_enable <= 1'b0;
        end
        else if (ctl_wr)
        begin
            ready_irq_enable <= wr_data[eeprom_access_pkg::CTL_RIE];
            program_op_select <= next_op;
        end
    end

    // Pointer and data registers; the pointer is frozen during a write.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            if (!program_strobe)
            begin
                nv_byte_pointer <= 12'h000;
            end
            nv_byte_value <= 8'h00;
        end
        else
        begin
            if (apply && (wr_sel == eeprom_access_pkg::SEL_POINTER) && !program_strobe)
            begin
                if (wr_strb[0])
                begin
                    nv_byte_pointer[7:0] <= wr_data[7:0];
                end
                if (wr_strb[1])
                begin
                    nv_byte_pointer[11:8] <= wr_data[11:8];
                end
            end
            if (rd_capture)
            begin
                nv_byte_value <= nv_rdata;
            end
            else if (apply && (wr_sel == eeprom_access_pkg::SEL_VALUE) && wr_strb[0])
            begin
                nv_byte_value <= wr_data[7:0];
            end
        end
    end

    // Array requests; address, data and action hold steady for a running write.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            if (!program_strobe)
            begin
                nv_addr <= 12'h000;
                nv_wdata <= 8'h00;
                nv_op <= eeprom_access_pkg::OP_RESET;
            end
            nv_write_start <= 1'b0;
            nv_rd_en <= 1'b0;
            rd_capture <= 1'b0;
        end
        else
        begin
            nv_write_start <= write_go;
            nv_rd_en <= read_go;
            rd_capture <= nv_rd_en;
            if (write_go || read_go)
            begin
                nv_addr <= nv_byte_pointer;
            end
            if (write_go)
            begin
                nv_wdata <= nv_byte_value;
                nv_op <= next_op;
            end
        end
    end

    // Sticky event flags; a new event wins over a clear in the same cycle.
    assign events = {(want_prog && !write_go) || (want_read && !read_go), rd_capture, write_done};
    genvar gi;
    generate
        for (gi = 0; gi < eeprom_access_pkg::EV_COUNT; gi++)
        begin : g_status
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                begin
                    irq_status[gi] <= 1'b0;
                end
                else if (events[gi])
                begin
                    irq_status[gi] <= 1'b1;
                end
                else if (apply && (wr_sel == eeprom_access_pkg::SEL_STATUS) && wr_strb[0]
                    && wr_data[gi])
                begin
                    irq_status[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // Mask, global enable and the two interrupt outputs.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            irq_mask <= 3'h0;
            global_irq_enable <= 1'b0;
            irq <= 1'b0;
            ready_irq <= 1'b0;
        end
        else
        begin
            if (apply && (wr_sel == eeprom_access_pkg::SEL_MASK) && wr_strb[0])
            begin
                irq_mask <= wr_data[eeprom_access_pkg::EV_COUNT-1:0];
            end
            if (apply && (wr_sel == eeprom_access_pkg::SEL_CONFIG) && wr_strb[0])
            begin
                global_irq_enable <= wr_data[0];
            end
            irq <= |(irq_status & irq_mask);
            ready_irq <= ready_irq_enable && global_irq_enable && !program_strobe;
        end
    end

    // Read data selection; the read strobe always reads back as zero.
    always_comb
    begin
        case (eeprom_access_pkg::reg_sel(araddr))
            eeprom_access_pkg::SEL_CONTROL: next_rdata = {26'h0, program_op_select,
                ready_irq_enable, master_write_arm, program_strobe, 1'b0};
            eeprom_access_pkg::SEL_POINTER: next_rdata = {20'h0, nv_byte_pointer};
            eeprom_access_pkg::SEL_VALUE: next_rdata = {24'h0, nv_byte_value};
            eeprom_access_pkg::SEL_STATUS: next_rdata = {29'h0, irq_status};
            eeprom_access_pkg::SEL_MASK: next_rdata = {29'h0, irq_mask};
            eeprom_access_pkg::SEL_CONFIG: next_rdata = {31'h0, global_irq_enable};
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    // Read channel: one read at a time, answered the cycle after the address.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= eeprom_access_pkg::RESP_OKAY;
        end
        else if (arvalid && arready)
        begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= next_rdata;
            rresp <= (eeprom_access_pkg::reg_sel(araddr) == eeprom_access_pkg::SEL_NONE)
                ? eeprom_access_pkg::RESP_SLVERR : eeprom_access_pkg::RESP_OKAY;
        end
        else if (rvalid && rready)
        begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end
        else if (!rvalid)
        begin
            arready <= 1'b1;
        end
    end

    // Checks on the write and read sequencing.
    sequence s_stall_two;
        cpu_stall [*2] ##1 !cpu_stall;
    endsequence
    sequence s_stall_four;
        cpu_stall [*4] ##1 !cpu_stall;
    endsequence

    AST_ARM_WINDOW: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(master_write_arm) |-> master_write_arm [*4] ##1 !master_write_arm)
        else $error("Arm bit did not last exactly four cycles.");
    AST_ARMED_START: assert property (@(posedge aclk) disable iff (!aresetn)
        nv_write_start |-> $past(master_write_arm))
        else $error("Write started without arming.");
    AST_START_TAKES: assert property (@(posedge aclk) disable iff (!aresetn)
        write_go |=> nv_write_start && program_strobe)
        else $error("Armed strobe did not start a write.");
    AST_FLASH_LOCK: assert property (@(posedge aclk) disable iff (!aresetn)
        nv_write_start |-> !$past(flash_self_program_active))
        else $error("Write started during flash programming.");
    AST_WRITE_STALL: assert property (@(posedge aclk) disable iff (!aresetn)
        write_go |=> s_stall_two)
        else $error("Write stall was not two cycles.");
    AST_READ_STALL: assert property (@(posedge aclk) disable iff (!aresetn)
        read_go |=> s_stall_four)
        else $error("Read stall was not four cycles.");
    AST_READ_DATA: assert property (@(posedge aclk) disable iff (!aresetn)
        nv_rd_en |-> ##2 (nv_byte_value == $past(nv_rdata)))
        else $error("Read byte not captured.");
    AST_BUSY_NO_READ: assert property (@(posedge aclk) disable iff (!aresetn)
        nv_rd_en |-> !$past(program_strobe))
        else $error("Read issued during a write.");
    AST_POINTER_HELD: assert property (@(posedge aclk)
        program_strobe && $past(program_strobe) |-> $stable(nv_byte_pointer))
        else $error("Pointer changed during a write.");
    AST_OP_HELD: assert property (@(posedge aclk)
        program_strobe && $past(program_strobe) |-> $stable(program_op_select))
        else $error("Operation select changed during a write.");
    AST_BUSY_END: assert property (@(posedge aclk)
        $past(program_strobe) && !program_strobe |-> write_done)
        else $error("Busy dropped without write completion.");
    AST_READY_IRQ: assert property (@(posedge aclk) disable iff (!aresetn)
        (ready_irq_enable && global_irq_enable && !program_strobe) |=> ready_irq)
        else $error("Ready interrupt missing while idle.");

endmodule // eeprom_byte_access_control

//--- rtl/eeprom_access_pkg.sv
// Purpose: Shared constants, types and decode for the EEPROM byte access block.
// Assumes: AXI4-Lite with 32-bit data, one register per aligned word.
// Notes: Write times are counted in calibrated RC oscillator ticks.
package eeprom_access_pkg;

    // Register byte offsets.
    localparam logic [4:0] OFS_CONTROL = 5'h00;
    localparam logic [4:0] OFS_POINTER = 5'h04;
    localparam logic [4:0] OFS_VALUE = 5'h08;
    localparam logic [4:0] OFS_STATUS = 5'h0c;
    localparam logic [4:0] OFS_MASK = 5'h10;
    localparam logic [4:0] OFS_CONFIG = 5'h14;

    // Decoded register selectors.
    localparam logic [2:0] SEL_CONTROL = 3'h0;
    localparam logic [2:0] SEL_POINTER = 3'h1;
    localparam logic [2:0] SEL_VALUE = 3'h2;
    localparam logic [2:0] SEL_STATUS = 3'h3;
    localparam logic [2:0] SEL_MASK = 3'h4;
    localparam logic [2:0] SEL_CONFIG = 3'h5;
    localparam logic [2:0] SEL_NONE = 3'h7;

    // Control register field positions.
    localparam int CTL_READ = 0;
    localparam int CTL_PROG = 1;
    localparam int CTL_ARM = 2;
    localparam int CTL_RIE = 3;
    localparam int CTL_OP_LO = 4;
    localparam int CTL_OP_HI = 5;

    // Programming actions.
    localparam logic [1:0] OP_ERASE_WRITE = 2'h0;
    localparam logic [1:0] OP_ERASE_ONLY = 2'h1;
    localparam logic [1:0] OP_WRITE_ONLY = 2'h2;
    localparam logic [1:0] OP_RESERVED = 2'h3;
    localparam logic [1:0] OP_RESET = 2'h0;

    // Interrupt status bit positions.
    localparam int EV_WRITE_DONE = 0;
    localparam int EV_READ_DONE = 1;
    localparam int EV_REFUSED = 2;
    localparam int EV_COUNT = 3;

    // Cycle counts for arming and CPU stalls.
    localparam logic [2:0] ARM_WINDOW = 3'h4;
    localparam logic [2:0] WRITE_STALL = 3'h2;
    localparam logic [2:0] READ_STALL = 3'h4;

    // Write time: oscillator ticks for the combined operation and its time in microseconds.
    localparam int ATOMIC_TIME_US = 3300;
    localparam int SPLIT_TIME_US = 1800;
    localparam int ATOMIC_TICKS_INT = 26368;
    localparam int SPLIT_TICKS_INT =
        (ATOMIC_TICKS_INT * SPLIT_TIME_US + ATOMIC_TIME_US - 1) / ATOMIC_TIME_US;
    localparam logic [14:0] ATOMIC_TICKS = 15'(ATOMIC_TICKS_INT);
    localparam logic [14:0] SPLIT_TICKS = 15'(SPLIT_TICKS_INT);

    // Bus responses.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Write channel sequencing.
    typedef enum logic [1:0]
    {
        WR_IDLE = 2'b00,
        WR_APPLY = 2'b01,
        WR_STALL = 2'b10,
        WR_RESP = 2'b11
    } wr_state_t;

    // Maps a byte address to a register selector; misaligned or unknown gives SEL_NONE.
    function automatic logic [2:0] reg_sel(input logic [4:0] addr);
        logic [2:0] sel;
        sel = SEL_NONE;
        case (addr)
            OFS_CONTROL: sel = SEL_CONTROL;
            OFS_POINTER: sel = SEL_POINTER;
            OFS_VALUE: sel = SEL_VALUE;
            OFS_STATUS: sel = SEL_STATUS;
            OFS_MASK: sel = SEL_MASK;
            OFS_CONFIG: sel = SEL_CONFIG;
            default: sel = SEL_NONE;
        endcase
        return sel;
    endfunction

endpackage

//--- rtl/nv_write_timer.sv
// Purpose: Times one EEPROM write in calibrated oscillator ticks.
// Assumes: rc_tick is a one-cycle pulse synchronous to aclk, one per oscillator cycle.
// Notes: A reset during a running write is ignored so the write completes.
`timescale 1ns/1ps
module nv_write_timer
(
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Control.
    input wire logic start,
    input wire logic [14:0] target,
    input wire logic rc_tick,
    // State.
    output logic busy,
    output logic done
);

    logic [14:0] count;
    logic [14:0] limit;

    // Counts ticks up to the latched limit; reset only acts while idle.
    // The test is arranged so that an unknown busy at power-up still takes the clearing branch.
    always_ff @(posedge aclk)
    begin
        if (aresetn || busy)
        begin
            done <= 1'b0;
            if (start && !busy)
            begin
                busy <= 1'b1;
                count <= 15'h0000;
                limit <= target;
            end
            else if (busy && rc_tick)
            begin
                count <= count + 15'h0001;
                if (count == limit - 15'h0001)
                begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
            end
        end
        else
        begin
            busy <= 1'b0;
            count <= 15'h0000;
            limit <= 15'h0000;
            done <= 1'b0;
        end
    end

endmodule // nv_write_timer

//--- verification/eeprom_byte_access_control_test.sv
// Purpose: Self-checking bench for EEPROM byte access over AXI4-Lite.
// Assumes: Short tick counts of 8 and 4 stand in for the real write times.
// Notes: The array model answers each address with its low byte xor 5a.
`timescale 1ns/1ps
module eeprom_byte_access_control_test;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [4:0] awaddr = 5'h00, araddr = 5'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, v;
    logic [1:0] r, tc = 2'h0;
    logic rc_tick = 1'b0, flash = 1'b0;
    logic [7:0] nv_rdata = 8'h00;
    logic awready, wready, bvalid, arready, rvalid, cpu_stall, ready_irq, irq, nv_ws, nv_re;
    logic [1:0] bresp, rresp, nv_op;
    logic [31:0] rdata;
    logic [11:0] nv_addr;
    logic [7:0] nv_wdata;
    int mismatches = 0, checks_done = 0;
    int stalls = 0, strobes = 0;
    eeprom_byte_access_control #(.TICKS_ATOMIC(15'h0008), .TICKS_SPLIT(15'h0004))
    u_eeprom_byte_access_control (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .rc_tick(rc_tick), .flash_self_program_active(flash),
        .nv_addr(nv_addr), .nv_wdata(nv_wdata), .nv_op(nv_op), .nv_write_start(nv_ws),
        .nv_rd_en(nv_re), .nv_rdata(nv_rdata), .cpu_stall(cpu_stall),
        .ready_irq(ready_irq), .irq(irq));
    // Clock of 40 ns period.
    always #20 aclk = ~aclk;
    // Oscillator tick every fourth cycle, and the array answering one cycle late.
    always @(posedge aclk)
    begin
        tc <= tc + 2'h1;
        rc_tick <= (tc == 2'h3);
        nv_rdata <= nv_addr[7:0] ^ 8'h5a;
        stalls <= stalls + int'(cpu_stall);
        strobes <= strobes + int'(nv_ws) + int'(nv_re);
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e)
        begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    // Address and data are offered together and each is dropped once taken.
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (awvalid || wvalid);
        bready <= 1'b1;
        do @(posedge aclk); while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, output logic [31:0] d);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        d = rdata;
        rready <= 1'b0;
    endtask
    // Polls the busy flag with a bound, then checks and clears the status.
    task automatic idle(input logic [31:0] st);
        rd(eeprom_access_pkg::OFS_CONTROL, v);
        for (int n = 0; n < 60 && v[1]; n++) rd(eeprom_access_pkg::OFS_CONTROL, v);
        rd(eeprom_access_pkg::OFS_STATUS, v);
        chk("status", st, v);
        chk("irq", {31'h0, st[0]}, {31'h0, irq});
        wr(eeprom_access_pkg::OFS_STATUS, 32'h7);
    endtask
    task automatic prog(input logic [31:0] op);
        wr(eeprom_access_pkg::OFS_CONFIG, 32'h0);
        wr(eeprom_access_pkg::OFS_CONTROL, op | 32'h4);
        wr(eeprom_access_pkg::OFS_CONTROL, op | 32'h2);
        wr(eeprom_access_pkg::OFS_CONFIG, 32'h1);
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // The whole run takes well under a millisecond of simulated time.
    initial
    begin
        #2000000;
        mismatches++;
        results;
    end
    initial
    begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        rd(eeprom_access_pkg::OFS_CONTROL, v);
        chk("control reset", 32'h0, v);
        wr(eeprom_access_pkg::OFS_CONTROL, 32'h2);
        idle(32'h4);
        wr(eeprom_access_pkg::OFS_MASK, 32'h1);
        wr(eeprom_access_pkg::OFS_CONFIG, 32'h1);
        wr(eeprom_access_pkg::OFS_POINTER, 32'h123);
        wr(eeprom_access_pkg::OFS_VALUE, 32'ha5);
        prog(32'h0);
        chk("array address", 32'h123, {20'h0, nv_addr});
        chk("array data", 32'ha5, {24'h0, nv_wdata});
        rd(eeprom_access_pkg::OFS_CONTROL, v);
        chk("busy", 32'h2, v & 32'h2);
        wr(eeprom_access_pkg::OFS_POINTER, 32'h055);
        wr(eeprom_access_pkg::OFS_CONTROL, 32'h11);
        rd(eeprom_access_pkg::OFS_POINTER, v);
        chk("pointer", 32'h123, v);
        chk("irq busy", 32'h0, {31'h0, irq});
        idle(32'h5);
        rd(eeprom_access_pkg::OFS_CONTROL, v);
        chk("op frozen", 32'h0, v);
        wr(eeprom_access_pkg::OFS_CONTROL, 32'h8);
        rd(eeprom_access_pkg::OFS_CONTROL, v);
        chk("ready irq", 32'h1, {31'h0, ready_irq});
        $display("write test done");
        wr(eeprom_access_pkg::OFS_CONTROL, 32'h4);
        repeat (8) @(posedge aclk);
        wr(eeprom_access_pkg::OFS_CONTROL, 32'h2);
        idle(32'h4);
        flash <= 1'b1;
        prog(32'h0);
        flash <= 1'b0;
        idle(32'h4);
        for (int op = 1; op < 4; op++)
        begin
            prog(op << 4);
            if (op != 3) chk("op", op, {30'h0, nv_op});
            idle((op == 3) ? 32'h4 : 32'h1);
        end
        $display("refusal and op test done");
        wr(eeprom_access_pkg::OFS_POINTER, 32'h00c);
        wr(eeprom_access_pkg::OFS_CONTROL, 32'h1);
        rd(eeprom_access_pkg::OFS_VALUE, v);
        chk("read byte", 32'h56, v);
        rd(eeprom_access_pkg::OFS_CONTROL, v);
        chk("strobes read zero", 32'h0, v);
        prog(32'h0);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(eeprom_access_pkg::OFS_CONTROL, v);
        chk("busy after reset", 32'h2, v & 32'h2);
        wr(eeprom_access_pkg::OFS_MASK, 32'h1);
        idle(32'h1);
        wr(5'h18, 32'h0);
        chk("unmapped", 32'h2, {30'h0, r});
        chk("stall cycles", 32'h0000000c, stalls);
        chk("array strobes", 32'h00000005, strobes);
        $display("read and reset test done");
        results;
    end
endmodule // eeprom_byte_access_control_test
